//--- src/bee_pkg.sv
// Constants, register map and types of the Boolean equation evaluator.
// Assumes a single 125 MHz clock and a 60 Hz power system line.
`default_nettype none

package bee_pkg;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int unsigned CLK_HZ = 125_000_000;
   localparam int unsigned LINE_FREQ_HZ = 60;
   localparam int unsigned PASSES_PER_LINE_CYCLE = 4;
   // One processing interval is a quarter of a line cycle, in ns
   localparam int unsigned PASS_TIME_NS =
      1_000_000_000 / (LINE_FREQ_HZ * PASSES_PER_LINE_CYCLE);
   // Longest time, so rounded down
   localparam int unsigned PASS_CYCLES = PASS_TIME_NS * (CLK_HZ / 1_000_000) / 1000;
   localparam int unsigned TICK_W = 20;

   // ************************************************************
   // Sizes
   // ************************************************************
   localparam int unsigned NEQ = 6;
   localparam int unsigned NPROD = 2;
   localparam int unsigned OPW = 16;
   localparam int unsigned NSTAT = 14;
   localparam int unsigned EQ_WORDS = 1 + 2 * NPROD;
   localparam int unsigned SHOT_W = 4;

   // Equations in their fixed evaluation order
   localparam logic [2:0] EQ_GEN_TRIP = 3'h0;
   localparam logic [2:0] EQ_COMM_TRIP = 3'h1;
   localparam logic [2:0] EQ_SOTF_TRIP = 3'h2;
   localparam logic [2:0] EQ_UNLATCH = 3'h3;
   localparam logic [2:0] EQ_EVENT = 3'h4;
   localparam logic [2:0] EQ_CONTACT = 3'h5;

   // ************************************************************
   // Register map (byte addresses)
   // ************************************************************
   localparam logic [11:0] EQ_REGION_END = 12'h0C0;
   localparam logic [11:0] CTRL_OFS = 12'h100;
   localparam logic [11:0] STAT_OFS = 12'h104;
   localparam logic [11:0] EVCNT_OFS = 12'h108;

   // Equation control word
   localparam int unsigned MODE_LSB = 0;
   localparam int unsigned INV_BIT = 4;
   localparam logic [1:0] MODE_CONST0 = 2'h0;
   localparam logic [1:0] MODE_CONST1 = 2'h1;
   localparam logic [1:0] MODE_EXPR = 2'h2;
   localparam logic [1:0] MODE_BLANK = 2'h3;
   localparam logic [31:0] EQ_WORD_RST = 32'h0000_0000;

   // Control register
   localparam int unsigned EN_BIT = 0;
   localparam int unsigned CAPLEN_LSB = 8;
   localparam logic EN_RST = 1'b1;
   localparam logic [7:0] CAPLEN_RST = 8'h04;

   // Status register
   localparam int unsigned RES_LSB = 0;
   localparam int unsigned TRIP_BIT = 8;
   localparam int unsigned CAP_BIT = 9;
   localparam int unsigned SHZ_BIT = 10;
   localparam int unsigned REJ_BIT = 16;

   typedef enum logic [3:0] {
      BEE_IDLE = 4'h1,
      BEE_EVAL = 4'h2,
      BEE_LATCH = 4'h4,
      BEE_DONE = 4'h8
   } bee_state_t;

endpackage

`default_nettype wire

//--- src/bee_evaluator.sv
// Boolean equation evaluator: sum-of-products equations over status bits,
// trip latch, event capture trigger and contact output, AHB-Lite registers.
// Assumes status bits and shot count come from logic on the mclk domain.
//
// The register addresses and the AHB-Lite interface to the registers are this design's own decisions.
`default_nettype none

module bee_evaluator #(
   parameter int unsigned PASS_CYCLES = bee_pkg::PASS_CYCLES
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [bee_pkg::NSTAT-1:0] status_bits,
   input wire logic [bee_pkg::SHOT_W-1:0] shot_count,
   input wire logic unlatch_permit,
   output logic trip_latched,
   output logic trip_output_contact,
   output logic [bee_pkg::NEQ-1:0] eq_result,
   output logic shot_zero_flag,
   output logic event_capture_active,
   output logic event_capture_start
);

   // ************************************************************
   // State
   // ************************************************************
   typedef logic [bee_pkg::EQ_WORDS-1:0][31:0] bee_eqcfg_t;

   typedef struct packed {
      bee_eqcfg_t [bee_pkg::NEQ-1:0] cfg;
      logic en;
      logic [7:0] caplen;
      bee_pkg::bee_state_t st;
      logic [2:0] idx;
      logic [bee_pkg::TICK_W-1:0] tick;
      logic [bee_pkg::NSTAT-1:0] snap;
      logic shz;
      logic [bee_pkg::OPW-1:0] prev;
      logic [bee_pkg::NEQ-1:0] res;
      logic trip;
      logic [7:0] capcnt;
      logic capact;
      logic evstart;
      logic [15:0] evcnt;
      logic rej;
      logic dwr;
      logic rdpend;
      logic [11:0] daddr;
      logic [31:0] rdata;
      logic rdy;
   } bee_regs_t;

   bee_regs_t q;
   bee_regs_t d;
   logic [bee_pkg::OPW-1:0] oper;
   logic eval_bit;
   logic pass_tick;
   logic acc;

   // ************************************************************
   // Equation evaluation
   // ************************************************************
   // Word 0 control, then per product: {neg,use} and {fall,rise}
   function automatic logic eq_eval(input bee_eqcfg_t w,
                                    input logic [bee_pkg::OPW-1:0] op,
                                    input logic [bee_pkg::OPW-1:0] pv);
      logic [bee_pkg::NPROD-1:0] prod;
      logic [bee_pkg::OPW-1:0] use_m;
      logic [bee_pkg::OPW-1:0] rise_m;
      logic [bee_pkg::OPW-1:0] fall_m;
      logic [bee_pkg::OPW-1:0] lit;
      logic sum;
      prod = '0;
      for (int p = 0; p < bee_pkg::NPROD; p++) begin
         use_m = w[1 + 2 * p][15:0];
         rise_m = w[2 + 2 * p][15:0];
         fall_m = w[2 + 2 * p][31:16] & ~rise_m;
         lit = (op & ~rise_m & ~fall_m) | (op & ~pv & rise_m);
         lit = lit | (~op & pv & fall_m);
         lit = lit ^ w[1 + 2 * p][31:16];
         prod[p] = (|use_m) & (&(lit | ~use_m));
      end
      sum = (|prod) ^ w[0][bee_pkg::INV_BIT];
      case (w[0][bee_pkg::MODE_LSB +: 2])
         bee_pkg::MODE_CONST0: eq_eval = 1'b0;
         bee_pkg::MODE_CONST1: eq_eval = 1'b1;
         default: eq_eval = sum;
      endcase
   endfunction

   function automatic logic [31:0] rd_word(input bee_regs_t r, input logic [11:0] a);
      logic [31:0] v;
      v = 32'h0000_0000;
      if (a < bee_pkg::EQ_REGION_END) begin
         if (a[7:5] < 3'(bee_pkg::NEQ) && a[4:2] < 3'(bee_pkg::EQ_WORDS)) begin
            v = r.cfg[a[7:5]][a[4:2]];
         end
      end else if (a == bee_pkg::CTRL_OFS) begin
         v[bee_pkg::EN_BIT] = r.en;
         v[bee_pkg::CAPLEN_LSB +: 8] = r.caplen;
      end else if (a == bee_pkg::STAT_OFS) begin
         v[bee_pkg::RES_LSB +: bee_pkg::NEQ] = r.res;
         v[bee_pkg::TRIP_BIT] = r.trip;
         v[bee_pkg::CAP_BIT] = r.capact;
         v[bee_pkg::SHZ_BIT] = r.shz;
         v[bee_pkg::REJ_BIT] = r.rej;
      end else if (a == bee_pkg::EVCNT_OFS) begin
         v[15:0] = r.evcnt;
      end
      rd_word = v;
   endfunction

   assign oper = {q.trip, q.shz, q.snap};
   assign eval_bit = eq_eval(q.cfg[q.idx], oper, q.prev);
   assign pass_tick = q.en && (q.tick == bee_pkg::TICK_W'(PASS_CYCLES - 1));
   assign acc = hsel && htrans[1] && hready;

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      d = q;
      d.evstart = 1'b0;
      if (!q.en || pass_tick) begin
         d.tick = '0;
      end else begin
         d.tick = q.tick + 1'b1;
      end

      case (q.st)
         bee_pkg::BEE_IDLE: begin
            if (pass_tick) begin
               d.snap = status_bits;
               d.shz = (shot_count == '0);
               d.idx = '0;
               d.st = bee_pkg::BEE_EVAL;
            end
         end
         bee_pkg::BEE_EVAL: begin
            d.res[q.idx] = eval_bit;
            if (q.idx == bee_pkg::EQ_EVENT && eval_bit && !q.res[bee_pkg::EQ_EVENT]
                && !q.capact) begin
               d.capact = 1'b1;
               d.capcnt = (q.caplen == 8'h00) ? 8'h01 : q.caplen;
               d.evstart = 1'b1;
               d.evcnt = q.evcnt + 16'h0001;
            end
            d.idx = q.idx + 3'h1;
            if (q.idx == bee_pkg::EQ_UNLATCH) begin
               d.st = bee_pkg::BEE_LATCH;
            end else if (q.idx == 3'(bee_pkg::NEQ - 1)) begin
               d.st = bee_pkg::BEE_DONE;
            end
         end
         bee_pkg::BEE_LATCH: begin
            // set is OR of three; release gated
            d.trip = q.res[bee_pkg::EQ_GEN_TRIP] | q.res[bee_pkg::EQ_COMM_TRIP]
                     | q.res[bee_pkg::EQ_SOTF_TRIP]
                     | (q.trip & ~(q.res[bee_pkg::EQ_UNLATCH] & unlatch_permit));
            d.st = bee_pkg::BEE_EVAL;
         end
         bee_pkg::BEE_DONE: begin
            d.prev = oper;
            if (q.capact) begin
               if (q.capcnt <= 8'h01) begin
                  d.capact = 1'b0;
                  d.capcnt = 8'h00;
               end else begin
                  d.capcnt = q.capcnt - 8'h01;
               end
            end
            d.st = bee_pkg::BEE_IDLE;
         end
         default: d.st = bee_pkg::BEE_IDLE;
      endcase

      // Bus data phase of a write
      if (q.dwr) begin
         if (q.daddr < bee_pkg::EQ_REGION_END) begin
            if (q.daddr[7:5] < 3'(bee_pkg::NEQ) && q.daddr[4:2] < 3'(bee_pkg::EQ_WORDS)) begin
               if (q.daddr[4:2] == 3'h0
                   && hwdata[bee_pkg::MODE_LSB +: 2] == bee_pkg::MODE_BLANK) begin
                  d.rej = 1'b1;
               end else begin
                  d.cfg[q.daddr[7:5]][q.daddr[4:2]] = hwdata;
               end
            end
         end else if (q.daddr == bee_pkg::CTRL_OFS) begin
            d.en = hwdata[bee_pkg::EN_BIT];
            d.caplen = hwdata[bee_pkg::CAPLEN_LSB +: 8];
         end else if (q.daddr == bee_pkg::STAT_OFS) begin
            if (hwdata[bee_pkg::REJ_BIT]) begin
               d.rej = 1'b0;
            end
         end
      end

      // One wait state on reads, so a prior write is always visible
      d.rdy = 1'b1;
      d.rdpend = 1'b0;
      d.dwr = acc && hwrite;
      if (acc) begin
         d.daddr = {haddr[11:2], 2'b00};
      end
      if (acc && !hwrite) begin
         d.rdpend = 1'b1;
         d.rdy = 1'b0;
      end
      if (q.rdpend) begin
         d.rdata = rd_word(q, q.daddr);
      end
   end

   // ************************************************************
   // Registers
   // ************************************************************
   always_ff @(posedge mclk) begin
      if (rst) begin
         q <= '0;
         q.en <= bee_pkg::EN_RST;
         q.caplen <= bee_pkg::CAPLEN_RST;
         q.st <= bee_pkg::BEE_IDLE;
         q.rdy <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign hrdata = q.rdata;
   assign hreadyout = q.rdy;
   assign hresp = 1'b0;
   assign trip_latched = q.trip;
   assign trip_output_contact = q.res[bee_pkg::EQ_CONTACT];
   assign eq_result = q.res;
   assign shot_zero_flag = q.shz;
   assign event_capture_active = q.capact;
   assign event_capture_start = q.evstart;

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   property p_shot_zero;
      (q.st == bee_pkg::BEE_IDLE && pass_tick) |=> (q.shz == ($past(shot_count) == '0));
   endproperty
   a_shot_zero: assert property (p_shot_zero) else $error("shot zero flag wrong");

   property p_trip_set;
      (q.st == bee_pkg::BEE_LATCH && (|q.res[2:0])) |=> q.trip;
   endproperty
   a_trip_set: assert property (p_trip_set) else $error("trip did not latch");

   property p_trip_release;
      $fell(q.trip) |-> $past(q.res[bee_pkg::EQ_UNLATCH] && unlatch_permit
                              && q.st == bee_pkg::BEE_LATCH);
   endproperty
   a_trip_release: assert property (p_trip_release) else $error("bad release");

   property p_trip_hold;
      (q.st != bee_pkg::BEE_LATCH) |=> $stable(q.trip);
   endproperty
   a_trip_hold: assert property (p_trip_hold) else $error("trip moved");

   property p_ev_start;
      q.evstart |-> q.capact && $past(!q.capact) && q.res[bee_pkg::EQ_EVENT]
                    && $past(!q.res[bee_pkg::EQ_EVENT]);
   endproperty
   a_ev_start: assert property (p_ev_start) else $error("event start bad");

   property p_ev_level;
      (q.st == bee_pkg::BEE_EVAL && q.idx == bee_pkg::EQ_EVENT && eval_bit
       && q.res[bee_pkg::EQ_EVENT]) |=> !q.evstart;
   endproperty
   a_ev_level: assert property (p_ev_level) else $error("level retrigger");

   property p_res_hold;
      !$stable(q.res) |-> $past(q.st == bee_pkg::BEE_EVAL);
   endproperty
   a_res_hold: assert property (p_res_hold) else $error("result changed off pass");

   property p_pass_len;
      (q.st == bee_pkg::BEE_IDLE && pass_tick) |=> (q.st == bee_pkg::BEE_EVAL) [*4]
         ##1 q.st == bee_pkg::BEE_LATCH ##1 (q.st == bee_pkg::BEE_EVAL) [*2]
         ##1 q.st == bee_pkg::BEE_DONE ##1 q.st == bee_pkg::BEE_IDLE;
   endproperty
   a_pass_len: assert property (p_pass_len) else $error("pass order broken");

   property p_prev;
      (q.st == bee_pkg::BEE_DONE) |=> q.prev == $past(oper);
   endproperty
   a_prev: assert property (p_prev) else $error("edge history stale");

   property p_reject;
      (q.dwr && q.daddr < bee_pkg::EQ_REGION_END && q.daddr[4:2] == 3'h0
       && hwdata[1:0] == bee_pkg::MODE_BLANK) |=> q.rej && $stable(q.cfg);
   endproperty
   a_reject: assert property (p_reject) else $error("blank form stored");

   property p_contact;
      (q.st == bee_pkg::BEE_EVAL && q.idx == bee_pkg::EQ_CONTACT)
         |=> trip_output_contact == $past(eval_bit);
   endproperty
   a_contact: assert property (p_contact) else $error("contact not updated");

   c_event: cover property (q.evstart);
   c_trip: cover property ($rose(q.trip));
   c_release: cover property ($fell(q.trip));
   c_reject: cover property ($rose(q.rej));

endmodule // bee_evaluator

`default_nettype wire

//--- test/bee_evaluator_tb.sv
// Self-checking bench for the Boolean equation evaluator.
// Assumes the evaluator's pass divider is shortened to 16 cycles for simulation.
`default_nettype none

module boolean_equation_evaluator_tb_top;
   timeunit 1ns;
   timeprecision 100ps;

   // ************************************************************
   // Signals and instance
   // ************************************************************
   localparam int PC = 16;
   // Two dividers plus ten cycles, more than the eight-cycle pass sequence
   localparam int SETTLE = 2 * PC + 10;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic [13:0] status_bits = 14'h0;
   logic [3:0] shot_count = 4'h0;
   logic unlatch_permit = 1'b0;
   logic trip_latched;
   logic trip_output_contact;
   logic [5:0] eq_result;
   logic shot_zero_flag;
   logic event_capture_active;
   logic event_capture_start;
   int failures = 0;
   int checked = 0;
   int starts = 0;
   int cyc = 0;
   int act = 0;

   bee_evaluator #(.PASS_CYCLES(PC)) dut (
      .mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .status_bits(status_bits), .shot_count(shot_count),
      .unlatch_permit(unlatch_permit), .trip_latched(trip_latched),
      .trip_output_contact(trip_output_contact), .eq_result(eq_result),
      .shot_zero_flag(shot_zero_flag), .event_capture_active(event_capture_active),
      .event_capture_start(event_capture_start)
   );

   always #4 mclk = ~mclk;

   always @(posedge mclk) begin
      if (event_capture_start === 1'b1) starts++;
      if (event_capture_active === 1'b1) act++;
      cyc++;
      // Whole run needs about 750 cycles
      if (cyc == 6000) begin
         failures++;
         summarize();
      end
   end

   // ************************************************************
   // Shared tasks
   // ************************************************************
   task automatic summarize();
      if (failures == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   // Entered right after a rising edge; leaves right after the completing edge
   task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd,
                       output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] x;
      xfer(a, 1'b1, d, x);
   endtask

   task automatic rdc(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e,
                      input string msg);
      logic [31:0] x;
      xfer(a, 1'b0, 32'h0, x);
      chk(x & m, e, msg);
   endtask

   task automatic apply(input logic [13:0] sb, input logic [3:0] sh, input logic pm);
      status_bits <= sb;
      shot_count <= sh;
      unlatch_permit <= pm;
      repeat (SETTLE) @(posedge mclk);
   endtask

   task automatic trip_is(input logic [1:0] e, input string msg);
      chk({30'h0, trip_latched, trip_output_contact}, {30'h0, e}, msg);
   endtask

   // Counts the cycles the event result stays high after it next rises
   task automatic pulse_len(input logic [13:0] sb, input string msg);
      int n;
      n = 0;
      status_bits <= sb;
      do begin
         @(posedge mclk);
         n++;
      end while (eq_result[4] !== 1'b1 && n < SETTLE);
      n = 0;
      while (eq_result[4] === 1'b1 && n < 100) begin
         n++;
         @(posedge mclk);
      end
      chk(n, PC, msg);
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_reset();
      chk({28'h0, trip_latched, hreadyout, hresp, event_capture_active}, 32'h4, "rst outs");
      chk({26'h0, eq_result}, 32'h0, "rst results");
      rdc(32'h100, 32'hFFFF_FFFF, {16'h0, bee_pkg::CAPLEN_RST, 7'h0, bee_pkg::EN_RST},
          "ctrl rst");
      rdc(32'h0, 32'hFFFF_FFFF, bee_pkg::EQ_WORD_RST, "eq word rst");
      rdc(32'h108, 32'hFFFF_FFFF, 32'h0, "evcnt rst");
      wr(32'h0F0, 32'hFFFF_FFFF);
      rdc(32'h0F0, 32'hFFFF_FFFF, 32'h0, "unmapped");
   endtask

   task automatic t_refuse();
      wr(32'h60, 32'h0000_0003);
      rdc(32'h60, 32'hFFFF_FFFF, 32'h0, "blank stored");
      rdc(32'h104, 32'h0001_0000, 32'h0001_0000, "reject flag");
      wr(32'h104, 32'h0001_0000);
      rdc(32'h104, 32'h0001_0000, 32'h0, "reject clear");
   endtask

   task automatic t_trip();
      // Gen trip: inst_oc*shot_zero + gnd_timeout; comm: ph_timeout
      // few bits each
      wr(32'h00, 32'h0000_0002);
      wr(32'h04, 32'h0000_4004);
      wr(32'h0C, 32'h0000_0002);
      wr(32'h20, 32'h0000_0002);
      wr(32'h24, 32'h0000_0001);
      // Unlatch: not (ph_pickup or gnd_pickup); contact: trip bit
      wr(32'h60, 32'h0000_0012);
      wr(32'h64, 32'h0000_0008);
      wr(32'h6C, 32'h0000_0010);
      wr(32'hA0, 32'h0000_0002);
      wr(32'hA4, 32'h0000_8000);
      apply(14'h0004, 4'h1, 1'b1);
      trip_is(2'h0, "inst at shot1");
      chk({31'h0, shot_zero_flag}, 32'h0, "shot1 flag");
      apply(14'h0004, 4'h0, 1'b1);
      trip_is(2'h3, "inst at shot0");
      chk({31'h0, shot_zero_flag}, 32'h1, "shot0 flag");
      apply(14'h0010, 4'h0, 1'b1);
      trip_is(2'h3, "held by pickup");
      chk({31'h0, eq_result[3]}, 32'h0, "unlatch group");
      apply(14'h0000, 4'h0, 1'b0);
      chk({31'h0, eq_result[3]}, 32'h1, "unlatch true");
      trip_is(2'h3, "held by permit");
      apply(14'h0000, 4'h0, 1'b1);
      trip_is(2'h0, "released");
      apply(14'h0002, 4'h2, 1'b1);
      trip_is(2'h3, "gnd timeout");
      apply(14'h0000, 4'h2, 1'b1);
      trip_is(2'h0, "released 2");
      apply(14'h0001, 4'h2, 1'b1);
      trip_is(2'h3, "comm trip");
      apply(14'h0000, 4'h2, 1'b1);
      chk({26'h0, eq_result}, 32'h08, "held results");
   endtask

   task automatic t_events();
      // Event: rise of bit6 + fall of bit7, capture one pass
      wr(32'h100, 32'h0000_0101);
      wr(32'h80, 32'h0000_0002);
      wr(32'h84, 32'h0000_0040);
      wr(32'h88, 32'h0000_0040);
      wr(32'h8C, 32'h0000_0080);
      wr(32'h90, 32'h0080_0000);
      apply(14'h0080, 4'h0, 1'b1);
      chk({31'h0, eq_result[4]}, 32'h0, "steady high");
      pulse_len(14'h00C0, "rise pulse");
      pulse_len(14'h0040, "fall pulse");
      repeat (SETTLE) @(posedge mclk);
      chk(starts, 2, "two captures");
      // Level form: second term joining adds no edge
      wr(32'h88, 32'h0000_0000);
      wr(32'h90, 32'h0000_0000);
      apply(14'h0040, 4'h0, 1'b1);
      apply(14'h00C0, 4'h0, 1'b1);
      chk(starts, 3, "level trigger");
      rdc(32'h108, 32'h0000_FFFF, 32'h3, "evcnt");
      // One-pass captures stay active two cycles each
      chk(act, 6, "capture active cycles");
   endtask

   initial begin
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      t_reset();
      t_refuse();
      t_trip();
      t_events();
      summarize();
   end

endmodule // boolean_equation_evaluator_tb_top

`default_nettype wire
